/* verilog/serial_flash_id_otp_security.v */
/*
  Serial flash command slice: wake from deep power-down, legacy signature,
  maker/part ID reads, secured OTP mode entry and exit, security register.
  Assumes SPI mode 0 pins sampled by clk (125 MHz) far faster than the serial
  clock, and that event and level inputs other than pins are on clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "flash_id_otp_map.vh"

module serial_flash_id_otp_security #(
  parameter WAKE_DELAY_CYCLES = `WAKE_DELAY_CYCLES,
  parameter CNT_W = 16,
  parameter [7:0] MAKER_ID = 8'h5A,      // Arbitrary value.
  parameter [7:0] PART_ID = 8'h3C,       // Arbitrary value.
  parameter [7:0] SIGNATURE_ID = 8'h6B   // Arbitrary value.
) (
  input wire clk,
  input wire reset_n,
  input wire chip_select_n,
  input wire serial_clk,
  input wire serial_in,
  input wire write_protect_n,
  output wire serial_out,
  output wire serial_out_oe,
  input wire write_busy,
  input wire sleep_enter,
  input wire cp_active,
  input wire prog_fail_evt,
  input wire erase_fail_evt,
  input wire protect_select_req,
  input wire nv_factory_lock,
  input wire nv_lockdown,
  input wire nv_protect_select,
  output wire deep_sleep,
  output wire standby,
  output wire otp_mode,
  output wire otp_read_only,
  output wire array_write_protect,
  output reg power_on_lock_all,
  output reg lockdown_program,
  output reg protect_select_program,
  output reg [7:0] security_status_reg
);

  localparam [1:0] ST_OPCODE = 2'd0;
  localparam [1:0] ST_ADDR = 2'd1;
  localparam [1:0] ST_OUT = 2'd2;
  localparam [1:0] ST_SINK = 2'd3;

  localparam [1:0] SRC_SIG = 2'd0;
  localparam [1:0] SRC_ID = 2'd1;
  localparam [1:0] SRC_SEC = 2'd2;

  wire cs_n_s, sclk_s, si_s, wp_n_s;
  wire selected, sclk_rise, sclk_fall, cs_rise, is_id_op;
  wire [7:0] byte_in;
  reg cs_n_prev_q, sclk_prev_q;

  reg [1:0] state_q, byte_cnt_q, frame_len_q, src_q;
  reg [2:0] bit_cnt_q, out_cnt_q;
  reg [7:0] shift_in_q, opcode_q, out_sh_q;
  reg cmd_ok_q, swap_q, alt_q, so_q, so_oe_q;

  reg sleep_q, waking_q, otp_mode_q, factory_q, lockdown_q;
  reg block_protect_select_q, pfail_q, efail_q, nv_loaded_q;
  reg [CNT_W-1:0] wake_cnt_q;

  wire frame_ok, do_wake, do_enter, do_exit, do_sec_write, do_fail_clear, do_block_protect_select;
  wire [7:0] sec_now, next_id;

  // ==========================================================================
  // Pin synchronisers.
  pin_sync #(.RESET_VAL(1'b1)) u_sync_cs (.clk(clk), .reset_n(reset_n),
    .pin_in(chip_select_n), .pin_sync_out(cs_n_s));

  pin_sync #(.RESET_VAL(1'b0)) u_sync_sclk (.clk(clk), .reset_n(reset_n),
    .pin_in(serial_clk), .pin_sync_out(sclk_s));

  pin_sync #(.RESET_VAL(1'b0)) u_sync_si (.clk(clk), .reset_n(reset_n),
    .pin_in(serial_in), .pin_sync_out(si_s));

  pin_sync #(.RESET_VAL(1'b1)) u_sync_wp (.clk(clk), .reset_n(reset_n),
    .pin_in(write_protect_n), .pin_sync_out(wp_n_s));

  // ==========================================================================
  // Edge detection on the synchronised pins.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_n_prev_q <= 1'b1;
      sclk_prev_q <= 1'b0;
    end else begin
      cs_n_prev_q <= cs_n_s;
      sclk_prev_q <= sclk_s;
    end
  end

  assign selected = ~cs_n_s;
  assign sclk_rise = selected & sclk_s & ~sclk_prev_q;
  assign sclk_fall = selected & ~sclk_s & sclk_prev_q;
  assign cs_rise = cs_n_s & ~cs_n_prev_q;
  assign byte_in = {shift_in_q[6:0], si_s};
  assign is_id_op = (byte_in == `OP_ID_READ) || (byte_in == `OP_ID_READ_DUAL) ||
                    (byte_in == `OP_ID_READ_QUAD) || (byte_in == `OP_ID_READ_QUAD_DDR);

  // ==========================================================================
  // Security register image, rebuilt every cycle so a read sees live state.
  assign sec_now = {block_protect_select_q, efail_q, pfail_q, cp_active, 2'b00, lockdown_q, factory_q};
  assign next_id = (alt_q ^ swap_q) ? MAKER_ID : PART_ID;

  // ==========================================================================
  // Frame decoder: opcode, dummy and address capture, then output phase.
  // The serial clock is much slower than clk, so a rise and a fall never
  // land in the same cycle and one process can own all frame state.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_OPCODE;
      bit_cnt_q <= 3'd0;
      byte_cnt_q <= 2'd0;
      frame_len_q <= 2'd0;
      shift_in_q <= 8'h00;
      opcode_q <= 8'h00;
      cmd_ok_q <= 1'b0;
      src_q <= SRC_SIG;
      swap_q <= 1'b0;
      alt_q <= 1'b0;
      out_sh_q <= 8'h00;
      out_cnt_q <= 3'd0;
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
    end else if (!selected) begin
      // Deselect ends any frame; the pin is released at once.
      state_q <= ST_OPCODE;
      bit_cnt_q <= 3'd0;
      byte_cnt_q <= 2'd0;
      frame_len_q <= 2'd0;
      cmd_ok_q <= 1'b0;
      so_oe_q <= 1'b0;
    end else if (sclk_rise) begin
      shift_in_q <= byte_in;
      bit_cnt_q <= bit_cnt_q + 3'd1;
      if (bit_cnt_q == 3'd7) begin
        if (frame_len_q != 2'd2) begin
          frame_len_q <= frame_len_q + 2'd1;
        end
        case (state_q)
          ST_OPCODE: begin
            opcode_q <= byte_in;
            if ((byte_in == `OP_WAKE) && !((sleep_q || waking_q) && write_busy)) begin
              cmd_ok_q <= 1'b1;
              state_q <= ST_OUT;
              src_q <= SRC_SIG;
              out_sh_q <= SIGNATURE_ID;
              out_cnt_q <= 3'd0;
            end else if (sleep_q || waking_q) begin
              // Asleep only wake or signature pass, and never over a write cycle.
              state_q <= ST_SINK;
            end else if (is_id_op) begin
              cmd_ok_q <= 1'b1;
              state_q <= ST_ADDR;
              byte_cnt_q <= 2'd0;
            end else if (byte_in == `OP_SECURITY_READ) begin
              // Allowed even while a program or erase cycle is busy.
              cmd_ok_q <= 1'b1;
              state_q <= ST_OUT;
              src_q <= SRC_SEC;
              out_sh_q <= sec_now;
              out_cnt_q <= 3'd0;
            end else begin
              cmd_ok_q <= 1'b1;
              state_q <= ST_SINK;
            end
          end
          ST_ADDR: begin
            byte_cnt_q <= byte_cnt_q + 2'd1;
            if (byte_cnt_q == `ID_DUMMY_BYTES) begin
              swap_q <= (byte_in == `ID_SWAP_ADDR);
              alt_q <= 1'b0;
              state_q <= ST_OUT;
              src_q <= SRC_ID;
              out_sh_q <= (byte_in == `ID_SWAP_ADDR) ? PART_ID : MAKER_ID;
              out_cnt_q <= 3'd0;
            end
          end
          default: begin
            state_q <= state_q;
          end
        endcase
      end
    end else if (sclk_fall && (state_q == ST_OUT)) begin
      // Drive MSB first on each falling edge and reload at byte ends.
      so_q <= out_sh_q[7];
      so_oe_q <= 1'b1;
      out_cnt_q <= out_cnt_q + 3'd1;
      if (out_cnt_q == 3'd7) begin
        case (src_q)
          SRC_SIG: out_sh_q <= SIGNATURE_ID;
          SRC_SEC: out_sh_q <= sec_now;
          SRC_ID: begin
            out_sh_q <= next_id;
            alt_q <= ~alt_q;
          end
          default: out_sh_q <= 8'h00;
        endcase
      end else begin
        out_sh_q <= {out_sh_q[6:0], 1'b0};
      end
    end
  end

  assign serial_out = so_q;
  assign serial_out_oe = so_oe_q;

  // ==========================================================================
  // Commands that act when chip select rises on a byte boundary; protect select acts on protect_select_req.
  // A partial last byte rejects them, so a noisy deselect does nothing.
  assign frame_ok = cs_rise && cmd_ok_q && (bit_cnt_q == 3'd0);
  assign do_wake = frame_ok && (opcode_q == `OP_WAKE);
  assign do_enter = frame_ok && (frame_len_q == 2'd1) && (opcode_q == `OP_ENTER_OTP);
  assign do_exit = frame_ok && (frame_len_q == 2'd1) && (opcode_q == `OP_EXIT_OTP);
  // No write-enable latch is consulted here; the OTP mode and lockdown gate it.
  assign do_sec_write = frame_ok && (frame_len_q == 2'd1) &&
                        (opcode_q == `OP_SECURITY_WRITE) &&
                        !otp_mode_q && !lockdown_q;
  assign do_fail_clear = frame_ok && (frame_len_q == 2'd1) && (opcode_q == `OP_FAIL_CLEAR);
  assign do_block_protect_select = protect_select_req && !otp_mode_q && !block_protect_select_q;

  // ==========================================================================
  // Power state: deep sleep, wake delay and standby.
  // The host must leave chip select high for the whole delay; a frame that
  // starts early is decoded as if still asleep and only wake is honoured.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sleep_q <= 1'b0;
      waking_q <= 1'b0;
      wake_cnt_q <= {CNT_W{1'b0}};
    end else if (do_wake) begin
      if (sleep_q) begin
        waking_q <= 1'b1;
        wake_cnt_q <= {CNT_W{1'b0}};
      end
    end else if (waking_q) begin
      if (wake_cnt_q == WAKE_DELAY_CYCLES[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1}) begin
        waking_q <= 1'b0;
        sleep_q <= 1'b0;
      end else begin
        wake_cnt_q <= wake_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end else if (sleep_enter && !write_busy) begin
      sleep_q <= 1'b1;
    end
  end

  assign deep_sleep = sleep_q;
  assign standby = ~sleep_q & ~waking_q;

  // ==========================================================================
  // Secured OTP mode.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      otp_mode_q <= 1'b0;
    end else if (do_enter) begin
      otp_mode_q <= 1'b1;
    end else if (do_exit) begin
      otp_mode_q <= 1'b0;
    end
  end

  assign otp_mode = otp_mode_q;
  assign otp_read_only = lockdown_q | factory_q;

  // ==========================================================================
  // Non-volatile bits: loaded once after reset, then only ever set.
  // Loading by a clocked process keeps the asynchronous reset constant-only.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      nv_loaded_q <= 1'b0;
      factory_q <= 1'b0;
      lockdown_q <= 1'b0;
      block_protect_select_q <= 1'b0;
      power_on_lock_all <= 1'b0;
      lockdown_program <= 1'b0;
      protect_select_program <= 1'b0;
    end else begin
      power_on_lock_all <= 1'b0;
      lockdown_program <= 1'b0;
      protect_select_program <= 1'b0;
      if (!nv_loaded_q) begin
        nv_loaded_q <= 1'b1;
        factory_q <= nv_factory_lock;
        lockdown_q <= nv_lockdown;
        block_protect_select_q <= nv_protect_select;
        power_on_lock_all <= nv_protect_select;
      end else begin
        if (do_sec_write) begin
          lockdown_q <= 1'b1;
          lockdown_program <= 1'b1;
        end
        if (do_block_protect_select) begin
          block_protect_select_q <= 1'b1;
          protect_select_program <= 1'b1;
        end
      end
    end
  end

  // In individual block mode a low protect pin overrides every lock bit.
  assign array_write_protect = block_protect_select_q & ~wp_n_s;

  // ==========================================================================
  // Fail flags: an event in the clearing cycle wins over the clear.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pfail_q <= `SEC_VOLATILE_RESET;
      efail_q <= `SEC_VOLATILE_RESET;
    end else begin
      pfail_q <= prog_fail_evt | (pfail_q & ~do_fail_clear);
      efail_q <= erase_fail_evt | (efail_q & ~do_fail_clear);
    end
  end

  // ==========================================================================
  // Registered copy of the security register for the surrounding logic.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      security_status_reg <= 8'h00;
    end else begin
      security_status_reg <= sec_now;
    end
  end

endmodule // serial_flash_id_otp_security

`default_nettype wire

/* verilog/flash_id_otp_map.vh */
/*
  Constants for the ID, wake and secured OTP command block: opcodes, security
  register bit positions and timing figures.
  Assumes one includer per compile unit; the guard stops double definition.
*/
`ifndef FLASH_ID_OTP_MAP_VH
`define FLASH_ID_OTP_MAP_VH

// ==========================================================================
// Clock and timing.
`define CLK_MHZ 125
`define WAKE_DELAY_NS 100000
`define WAKE_DELAY_CYCLES ((`WAKE_DELAY_NS * `CLK_MHZ + 999) / 1000)

// ==========================================================================
// Opcodes.
`define OP_WAKE 8'hAB
`define OP_ID_READ 8'h90
`define OP_ID_READ_DUAL 8'hCF
`define OP_ID_READ_QUAD 8'hDF
`define OP_ID_READ_QUAD_DDR 8'hEF
`define OP_ENTER_OTP 8'hB1
`define OP_EXIT_OTP 8'hC1
`define OP_SECURITY_READ 8'h2B
`define OP_SECURITY_WRITE 8'h2F
`define OP_FAIL_CLEAR 8'h30

// ==========================================================================
// ID read framing.
`define ID_DUMMY_BYTES 2'h2
`define ID_SWAP_ADDR 8'h01

// ==========================================================================
// Security register bit positions and reset value of its volatile part.
`define SEC_FACTORY_BIT 0
`define SEC_LOCKDOWN_BIT 1
`define SEC_CP_BIT 4
`define SEC_PFAIL_BIT 5
`define SEC_EFAIL_BIT 6
`define SEC_BLOCK_PROTECT_SELECT_BIT 7
`define SEC_VOLATILE_RESET 1'b0

`endif

/* verilog/pin_sync.v */
/*
  Two flip-flop synchroniser for one pin input.
  Assumes the input is asynchronous to clk; only the second stage is read.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter RESET_VAL = 1'b0
) (
  input wire clk,
  input wire reset_n,
  input wire pin_in,
  output wire pin_sync_out
);

  reg stage1_q;
  reg stage2_q;

  // ========================================================================
  // Synchroniser.
  // The first stage may go metastable, so nothing but the second stage sees it.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1_q <= RESET_VAL;
      stage2_q <= RESET_VAL;
    end else begin
      stage1_q <= pin_in;
      stage2_q <= stage1_q;
    end
  end

  assign pin_sync_out = stage2_q;

endmodule // pin_sync

`default_nettype wire

/* verif/flash_slice_chk.sv */
/*
  Checker for the ID, wake, OTP and security slice: watches the top ports.
  Assumes it is bound into the slice, one clock domain on clk.
*/
`timescale 1ns/1ps
`default_nettype none

// ====================
// Port relations.
module flash_slice_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic chip_select_n,
  input wire logic write_protect_n,
  input wire logic serial_out_oe,
  input wire logic write_busy,
  input wire logic cp_active,
  input wire logic prog_fail_evt,
  input wire logic erase_fail_evt,
  input wire logic deep_sleep,
  input wire logic standby,
  input wire logic otp_mode,
  input wire logic otp_read_only,
  input wire logic array_write_protect,
  input wire logic power_on_lock_all,
  input wire logic lockdown_program,
  input wire logic protect_select_program,
  input wire logic [7:0] security_status_reg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Power state: sleep and standby never overlap, and leaving sleep means standby.
  AST_SLEEP_NOT_READY: assert property (deep_sleep |-> !standby)
    else $error("standby high in deep sleep");
  AST_WAKE_DONE: assert property ($fell(deep_sleep) |-> $rose(standby))
    else $error("sleep left without standby");
  AST_BUSY_SLEEP: assert property (deep_sleep && write_busy |=> deep_sleep)
    else $error("woke during a write cycle");
  // The synchroniser lag is under six cycles, so a long deselect must free the pin.
  AST_OE_IDLE: assert property (chip_select_n [*6] |-> !serial_out_oe)
    else $error("output driven while deselected");
  // Status bits follow their causes within the register's lag.
  AST_CP_SET: assert property ($rose(cp_active) |-> ##[1:3] security_status_reg[4])
    else $error("cp bit not set");
  AST_CP_CLR: assert property (!cp_active [*4] |-> !security_status_reg[4])
    else $error("cp bit stuck");
  AST_PFAIL: assert property (prog_fail_evt |-> ##[1:3] security_status_reg[5])
    else $error("program fail bit not set");
  AST_EFAIL: assert property (erase_fail_evt |-> ##[1:3] security_status_reg[6])
    else $error("erase fail bit not set");
  // One-time bits never drop back while powered.
  AST_BLOCK_PROTECT_SELECT_KEEP: assert property (security_status_reg[7] |=> security_status_reg[7])
    else $error("protect select bit cleared");
  AST_OTP_LOCKDOWN_BIT_KEEP: assert property (security_status_reg[1] |=> security_status_reg[1])
    else $error("lockdown bit cleared");
  AST_LOCKED_RO: assert property (security_status_reg[1] |-> otp_read_only)
    else $error("locked area not read only");
  AST_LD_GATE: assert property
    (lockdown_program |-> !otp_mode && !security_status_reg[1])
    else $error("lockdown written when refused");
  AST_PS_GATE: assert property
    (protect_select_program |-> !otp_mode && !security_status_reg[7])
    else $error("protect select written when refused");
  AST_AWP: assert property
    ((security_status_reg[7] && !write_protect_n) [*6] |-> array_write_protect)
    else $error("array not protected");
  AST_POL_PULSE: assert property (power_on_lock_all |=> !power_on_lock_all)
    else $error("power on lock longer than one cycle");

  // Main scenarios reached.
  cover property ($fell(deep_sleep));
  cover property (lockdown_program);
  cover property (protect_select_program);
  cover property (power_on_lock_all);
endmodule // flash_slice_chk

bind serial_flash_id_otp_security flash_slice_chk chk (.*);

`default_nettype wire

/* verif/spi_host_model.sv */
/*
  Host SPI controller model: mode 0 frames, MSB first, replies sampled on rise.
  Assumes frame() is called with the device out of reset and synchronised.
*/
`timescale 1ns/1ps
`default_nettype none

// ====================
// Frame driver.
module spi_host_model (
  output var logic chip_select_n,
  output var logic serial_clk,
  input wire logic serial_out,
  output var logic serial_in
);
  // Clock idles low between frames, so the device sees no stray edges.
  initial begin
    chip_select_n = 1'b1;
    serial_clk = 1'b0;
    serial_in = 1'b0;
  end

  // Sends nb bytes from the top of tx, then clocks nrx reply bytes into rx.
  task automatic frame(input logic [31:0] tx, input int nb, input int nrx,
                       output logic [23:0] rx);
    int i;
    rx = 24'h0;
    chip_select_n = 1'b0;
    #40;
    for (i = 0; i < (nb + nrx) * 8; i++) begin
      // Past the address the line is unused; a toggling value keeps it honest.
      serial_in = (i < nb * 8) ? tx[31 - i] : ~serial_in;
      #40 serial_clk = 1'b1;
      if (i >= nb * 8)
        rx = {rx[22:0], serial_out};
      #40 serial_clk = 1'b0;
    end
    #40 chip_select_n = 1'b1;
    serial_in = ~serial_in;
    // Hold the deselect five clk periods so back-to-back frames stay apart.
    #40;
  endtask
endmodule // spi_host_model

`default_nettype wire

/* verif/serial_flash_id_otp_security_tb_top.sv */
/*
  Bench for the ID, wake, OTP and security slice, driven through the host model.
  Assumes a 125 MHz clock and a wake delay shortened to WD cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`include "flash_id_otp_map.vh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (e)); end end

// ====================
// Bench top.
module serial_flash_id_otp_security_tb_top;
  localparam int WD = 20;
  localparam logic [7:0] MK = 8'h5A; // Arbitrary value.
  localparam logic [7:0] PT = 8'h3C; // Arbitrary value.
  localparam logic [7:0] SG = 8'h6B; // Arbitrary value.
  logic clk, reset_n, write_protect_n, write_busy, sleep_enter, cp_active;
  logic prog_fail_evt, erase_fail_evt, protect_select_req;
  logic nv_factory_lock, nv_lockdown, nv_protect_select;
  wire chip_select_n, serial_clk, serial_in, serial_out, serial_out_oe;
  wire deep_sleep, standby, otp_mode, otp_read_only, array_write_protect;
  wire power_on_lock_all, lockdown_program, protect_select_program;
  wire [7:0] security_status_reg;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n;
  logic [23:0] rx;
  logic [7:0] ops [4] = '{`OP_ID_READ, `OP_ID_READ_DUAL, `OP_ID_READ_QUAD, `OP_ID_READ_QUAD_DDR};

  serial_flash_id_otp_security #(.WAKE_DELAY_CYCLES(WD), .MAKER_ID(MK), .PART_ID(PT),
    .SIGNATURE_ID(SG)) dut (.*);
  spi_host_model host (.*);

  // Free-running system clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Cuts a hang short; the scenarios need well under a third of this.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test;
    end
  end

  task stop_test;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task tick;
    @(posedge clk);
    #1;
  endtask

  // One-cycle strobe on {sleep_enter, prog_fail_evt, erase_fail_evt, protect_select_req}.
  task automatic pulse(input logic [3:0] m);
    tick;
    {sleep_enter, prog_fail_evt, erase_fail_evt, protect_select_req} = m;
    tick;
    {sleep_enter, prog_fail_evt, erase_fail_evt, protect_select_req} = 4'h0;
  endtask

  // Single-byte command, then time for the frame's effect to land.
  task automatic cmd(input logic [7:0] op);
    host.frame({op, 24'h0}, 1, 0, rx);
    repeat (8) tick;
  endtask

  // Scenario sequence.
  initial begin
    reset_n = 1'b0;
    write_protect_n = 1'b1;
    {write_busy, sleep_enter, cp_active, prog_fail_evt} = 4'h0;
    {erase_fail_evt, protect_select_req, nv_lockdown, nv_protect_select} = 4'h0;
    nv_factory_lock = 1'b1;
    repeat (16) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (4) tick;
    `CHK(standby, 1'b1)
    host.frame({`OP_SECURITY_READ, 24'h0}, 1, 2, rx);
    `CHK(rx[15:0], 16'h0101)
    host.frame({`OP_WAKE, 24'h0}, 1, 2, rx);
    `CHK(rx[15:0], ({SG, SG}))
    tick;
    `CHK(standby, 1'b1)
    for (int i = 0; i < 4; i++) begin
      host.frame({ops[i], 16'h0, 7'h0, i[0]}, 4, 3, rx);
      `CHK(rx, (i[0] ? {PT, MK, PT} : {MK, PT, MK}))
    end
    // Sleep, a wake refused while a write cycle runs, then a real wake.
    pulse(4'h8);
    tick;
    `CHK(({deep_sleep, standby}), 2'b10)
    write_busy = 1'b1;
    cmd(`OP_WAKE);
    `CHK(deep_sleep, 1'b1)
    write_busy = 1'b0;
    host.frame({`OP_WAKE, 24'h0}, 1, 0, rx);
    n = 0;
    while (standby !== 1'b1 && n < 200) begin
      tick;
      n++;
    end
    `CHK(n >= WD - 5 && n <= WD + 2, 1'b1)
    repeat (WD) tick;
    `CHK(({deep_sleep, standby}), 2'b01)
    // Secured area mode and the lockdown bit.
    cmd(`OP_ENTER_OTP);
    `CHK(otp_mode, 1'b1)
    cmd(`OP_SECURITY_WRITE);
    `CHK(security_status_reg, 8'h01)
    cmd(`OP_EXIT_OTP);
    `CHK(otp_mode, 1'b0)
    cmd(`OP_SECURITY_WRITE);
    `CHK(({security_status_reg, otp_read_only}), 9'h007)
    // Volatile flags, read during a write cycle, then cleared.
    cp_active = 1'b1;
    pulse(4'h4);
    pulse(4'h2);
    write_busy = 1'b1;
    host.frame({`OP_SECURITY_READ, 24'h0}, 1, 2, rx);
    `CHK(rx[15:0], 16'h7373)
    write_busy = 1'b0;
    cp_active = 1'b0;
    cmd(`OP_FAIL_CLEAR);
    `CHK(security_status_reg, 8'h03)
    // Protection select and the write protect pin.
    pulse(4'h1);
    write_protect_n = 1'b0;
    repeat (8) tick;
    `CHK(({security_status_reg[7], array_write_protect}), 2'b11)
    write_protect_n = 1'b1;
    repeat (8) tick;
    `CHK(array_write_protect, 1'b0)
    // Power cycle with the lockdown and protect select bits set, factory bit clear.
    reset_n = 1'b0;
    {nv_factory_lock, nv_lockdown, nv_protect_select} = 3'h3;
    repeat (4) tick;
    reset_n = 1'b1;
    n = 0;
    repeat (3) begin
      tick;
      n += (power_on_lock_all === 1'b1);
    end
    `CHK(n, 1)
    repeat (4) tick;
    `CHK(security_status_reg, 8'h82)
    stop_test;
  end
endmodule // serial_flash_id_otp_security_tb_top

`default_nettype wire
